// ---- core/clkdiv_consts.svh ----
// register offsets, field positions and reset values of the channel dividers
`ifndef CLKDIV_CONSTS_SVH
`define CLKDIV_CONSTS_SVH

`define CLKDIV_ADDR_W         12
`define CLKDIV_DATA_W         8

// register offsets
`define OFS_CH1_COUNTS        12'h0193
`define OFS_CH1_CONTROL       12'h0194
`define OFS_CH1_POWER         12'h0195
`define OFS_CH2_COUNTS        12'h0196
`define OFS_CH2_CONTROL       12'h0197
`define OFS_CH2_POWER         12'h0198
`define OFS_STATUS            12'h01A0

// field positions
`define FLD_LOW_HI            7
`define FLD_LOW_LO            4
`define FLD_HIGH_HI           3
`define FLD_HIGH_LO           0
`define FLD_BYPASS            7
`define FLD_IGNORE_SYNC       6
`define FLD_FORCE_LEVEL       5
`define FLD_START_HIGH        4
`define FLD_PHASE_HI          3
`define FLD_PHASE_LO          0
`define FLD_POWER_DOWN        2
`define FLD_DCC_DISABLE       0

// status register fields
`define STS_CH1_LEVEL         0
`define STS_CH2_LEVEL         1
`define STS_SYNC_HELD         2
`define STS_CH1_RUN           3
`define STS_CH2_RUN           4

// reset values
`define RST_CH1_COUNT         4'h3
`define RST_CH2_COUNT         4'h1
`define RST_PHASE             4'h0
`define RST_BIT               1'b0
`define RST_DATA              8'h00
`define PAIRS_PER_CHANNEL     3

`endif

// ---- core/clkdiv_pkg.sv ----
// types shared by the divider register file and the divider core
package clkdiv_pkg;

  typedef struct packed {
    logic [3:0] low_count;
    logic [3:0] high_count;
    logic       bypass;
    logic       ignore_sync;
    logic       force_level;
    logic       start_high;
    logic [3:0] phase;
    logic       power_down;
    logic       dcc_disable;
  } chan_cfg_type;

  typedef struct packed {
    logic level;
    logic running;
    logic bypassed;
  } chan_state_type;

  typedef enum logic [1:0] {
    DIV_STOPPED,
    DIV_DELAY,
    DIV_RUN
  } div_state_type;

endpackage : clkdiv_pkg

// ---- core/clkdiv_core.sv ----
// one programmable low/high divider with sync, force, phase and duty correction
`timescale 1ns/1ps
`include "clkdiv_consts.svh"

module clkdiv_core (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // configuration and sync
  input  wire clkdiv_pkg::chan_cfg_type cfg,
  input  wire logic                    sync_held,
  input  wire logic                    sync_release,
  // divider state
  output clkdiv_pkg::chan_state_type   state
);

  clkdiv_pkg::div_state_type st;
  logic [5:0]                cnt;
  logic                      level;
  logic [5:0]                len_high;
  logic [5:0]                len_low;
  logic [5:0]                total;
  logic                      obey;
  logic                      stopped;

  // a field always counts one more cycle than it holds
  function automatic logic [5:0] cycles(input logic [3:0] field);
    cycles = {2'b00, field} + 6'h01;
  endfunction : cycles

  assign obey    = !cfg.ignore_sync;
  assign stopped = cfg.power_down || cfg.bypass;
  assign total   = cycles(cfg.low_count) + cycles(cfg.high_count);

  // correction keeps the total but splits it evenly; odd totals favour low
  always_comb begin
    if (cfg.dcc_disable) begin
      len_high = cycles(cfg.high_count);
      len_low  = cycles(cfg.low_count);
    end else begin
      len_high = total >> 1;
      len_low  = total - (total >> 1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st    <= clkdiv_pkg::DIV_DELAY;
      cnt   <= 6'h00;
      level <= 1'b0;
    end else if (ce) begin
      if (stopped) begin
        // bypass powers the counter down; the mux outside takes over
        st    <= clkdiv_pkg::DIV_DELAY;
        cnt   <= {2'b00, cfg.phase};
        level <= 1'b0;
      end else if (cfg.ignore_sync && cfg.force_level) begin
        st    <= clkdiv_pkg::DIV_STOPPED;
        level <= 1'b1;
      end else if (obey && sync_held) begin
        st    <= clkdiv_pkg::DIV_STOPPED;
        level <= cfg.force_level;
      end else if ((obey && sync_release) ||
                   st == clkdiv_pkg::DIV_STOPPED) begin
        st    <= clkdiv_pkg::DIV_DELAY;
        cnt   <= {2'b00, cfg.phase};
        level <= cfg.start_high;
      end else begin
        case (st)
          clkdiv_pkg::DIV_DELAY: begin
            level <= cfg.start_high;
            if (cnt == 6'h00) begin
              st  <= clkdiv_pkg::DIV_RUN;
              cnt <= (cfg.start_high ? len_high : len_low) - 6'h01;
            end else begin
              cnt <= cnt - 6'h01;
            end
          end
          clkdiv_pkg::DIV_RUN: begin
            if (cnt == 6'h00) begin
              level <= !level;
              cnt   <= (level ? len_low : len_high) - 6'h01;
            end else begin
              cnt <= cnt - 6'h01;
            end
          end
          default: begin
            st  <= clkdiv_pkg::DIV_DELAY;
            cnt <= 6'h00;
          end
        endcase
      end
    end
  end

  assign state.level    = level && !stopped;
  assign state.running  = (st == clkdiv_pkg::DIV_RUN) && !stopped;
  assign state.bypassed = cfg.bypass && !cfg.power_down;

endmodule : clkdiv_core

// ---- core/clkdiv_top.sv ----
// register file, sync input and output stage of two channel dividers
//
// Functional notes
// - low time is low field plus one
// - high time is high field plus one
// - bypass powers divider down, passes input
// - ignore bit clear obeys sync, set ignores
// - force bit picks static output level
// - start bit picks first output level
// - four-bit phase offset, resets to zero
// - power-down puts three pairs high impedance
// - duty correction on unless disable bit set
// - second channel counts reset to one
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "clkdiv_consts.svh"

module clkdiv_top #(
  parameter int CHANNELS = 2
) (
  // clock, reset, enable
  input  wire logic                        CLK_I,
  input  wire logic                        SYS_RST_I,
  input  wire logic                        CE_I,
  // register port
  input  wire logic [`CLKDIV_ADDR_W-1:0]   ADDR_I,
  input  wire logic [`CLKDIV_DATA_W-1:0]   WDATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [`CLKDIV_DATA_W-1:0]   RDATA_O,
  // chip-level sync pin, high holds obeying dividers
  input  wire logic                        SYNC_I,
  // divider outputs, index 0 is channel one
  output logic      [CHANNELS-1:0]         DIV_O,
  output logic      [CHANNELS-1:0]         BYPASS_O,
  output logic      [CHANNELS*3-1:0]       OUT_EN_O
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  clkdiv_pkg::chan_cfg_type   cfg [CHANNELS];
  clkdiv_pkg::chan_state_type st  [CHANNELS];

  logic                       wr_ch1_counts;
  logic                       wr_ch1_control;
  logic                       wr_ch1_power;
  logic                       wr_ch2_counts;
  logic                       wr_ch2_control;
  logic                       wr_ch2_power;

  assign wr_ch1_counts  = WR_I && ADDR_I == `OFS_CH1_COUNTS;
  assign wr_ch1_control = WR_I && ADDR_I == `OFS_CH1_CONTROL;
  assign wr_ch1_power   = WR_I && ADDR_I == `OFS_CH1_POWER;
  assign wr_ch2_counts  = WR_I && ADDR_I == `OFS_CH2_COUNTS;
  assign wr_ch2_control = WR_I && ADDR_I == `OFS_CH2_CONTROL;
  assign wr_ch2_power   = WR_I && ADDR_I == `OFS_CH2_POWER;

  // channel one counts
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[0].low_count  <= `RST_CH1_COUNT;
      cfg[0].high_count <= `RST_CH1_COUNT;
    end else if (CE_I && wr_ch1_counts) begin
      cfg[0].low_count  <= WDATA_I[`FLD_LOW_HI:`FLD_LOW_LO];
      cfg[0].high_count <= WDATA_I[`FLD_HIGH_HI:`FLD_HIGH_LO];
    end
  end

  // channel one control
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[0].bypass      <= `RST_BIT;
      cfg[0].ignore_sync <= `RST_BIT;
      cfg[0].force_level <= `RST_BIT;
      cfg[0].start_high  <= `RST_BIT;
      cfg[0].phase       <= `RST_PHASE;
    end else if (CE_I && wr_ch1_control) begin
      cfg[0].bypass      <= WDATA_I[`FLD_BYPASS];
      cfg[0].ignore_sync <= WDATA_I[`FLD_IGNORE_SYNC];
      cfg[0].force_level <= WDATA_I[`FLD_FORCE_LEVEL];
      cfg[0].start_high  <= WDATA_I[`FLD_START_HIGH];
      cfg[0].phase       <= WDATA_I[`FLD_PHASE_HI:`FLD_PHASE_LO];
    end
  end

  // channel one power and duty correction
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[0].power_down  <= `RST_BIT;
      cfg[0].dcc_disable <= `RST_BIT;
    end else if (CE_I && wr_ch1_power) begin
      cfg[0].power_down  <= WDATA_I[`FLD_POWER_DOWN];
      cfg[0].dcc_disable <= WDATA_I[`FLD_DCC_DISABLE];
    end
  end

  // channel two counts
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[1].low_count  <= `RST_CH2_COUNT;
      cfg[1].high_count <= `RST_CH2_COUNT;
    end else if (CE_I && wr_ch2_counts) begin
      cfg[1].low_count  <= WDATA_I[`FLD_LOW_HI:`FLD_LOW_LO];
      cfg[1].high_count <= WDATA_I[`FLD_HIGH_HI:`FLD_HIGH_LO];
    end
  end

  // channel two control
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[1].bypass      <= `RST_BIT;
      cfg[1].ignore_sync <= `RST_BIT;
      cfg[1].force_level <= `RST_BIT;
      cfg[1].start_high  <= `RST_BIT;
      cfg[1].phase       <= `RST_PHASE;
    end else if (CE_I && wr_ch2_control) begin
      cfg[1].bypass      <= WDATA_I[`FLD_BYPASS];
      cfg[1].ignore_sync <= WDATA_I[`FLD_IGNORE_SYNC];
      cfg[1].force_level <= WDATA_I[`FLD_FORCE_LEVEL];
      cfg[1].start_high  <= WDATA_I[`FLD_START_HIGH];
      cfg[1].phase       <= WDATA_I[`FLD_PHASE_HI:`FLD_PHASE_LO];
    end
  end

  // channel two power and duty correction
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cfg[1].power_down  <= `RST_BIT;
      cfg[1].dcc_disable <= `RST_BIT;
    end else if (CE_I && wr_ch2_power) begin
      cfg[1].power_down  <= WDATA_I[`FLD_POWER_DOWN];
      cfg[1].dcc_disable <= WDATA_I[`FLD_DCC_DISABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync pin: two-stage synchroniser, then release detect

  logic sync_meta;
  logic sync_sync;
  logic sync_prev;
  logic sync_release;

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
    end else if (CE_I) begin
      sync_meta <= SYNC_I;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  // release is the realignment point, so all obeying dividers leave together
  assign sync_release = sync_prev && !sync_sync;

  ////////////////////////////////////////////////////////////////////////////
  // divider cores

  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    clkdiv_core u_core (
      .clk          (CLK_I),
      .rst          (SYS_RST_I),
      .ce           (CE_I),
      .cfg          (cfg[c]),
      .sync_held    (sync_sync),
      .sync_release (sync_release),
      .state        (st[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage, all registered

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DIV_O    <= '0;
      BYPASS_O <= '0;
    end else if (CE_I) begin
      for (int c = 0; c < CHANNELS; c++) begin
        DIV_O[c]    <= st[c].level;
        BYPASS_O[c] <= st[c].bypassed;
      end
    end
  end

  // enables drop together so the three pairs float as one group
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      OUT_EN_O <= '0;
    end else if (CE_I) begin
      for (int c = 0; c < CHANNELS; c++) begin
        OUT_EN_O[c*`PAIRS_PER_CHANNEL +: `PAIRS_PER_CHANNEL] <=
          {`PAIRS_PER_CHANNEL{!cfg[c].power_down}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand only in the cycle after the strobe

  logic [`CLKDIV_DATA_W-1:0] next_rdata;

  function automatic logic [7:0] pack_counts(
    input clkdiv_pkg::chan_cfg_type c
  );
    pack_counts = {c.low_count, c.high_count};
  endfunction : pack_counts

  function automatic logic [7:0] pack_control(
    input clkdiv_pkg::chan_cfg_type c
  );
    pack_control = {c.bypass, c.ignore_sync, c.force_level, c.start_high,
                    c.phase};
  endfunction : pack_control

  function automatic logic [7:0] pack_power(
    input clkdiv_pkg::chan_cfg_type c
  );
    pack_power = `RST_DATA;
    pack_power[`FLD_POWER_DOWN]  = c.power_down;
    pack_power[`FLD_DCC_DISABLE] = c.dcc_disable;
  endfunction : pack_power

  always_comb begin
    next_rdata = `RST_DATA;
    case (ADDR_I)
      `OFS_CH1_COUNTS:  next_rdata = pack_counts(cfg[0]);
      `OFS_CH1_CONTROL: next_rdata = pack_control(cfg[0]);
      `OFS_CH1_POWER:   next_rdata = pack_power(cfg[0]);
      `OFS_CH2_COUNTS:  next_rdata = pack_counts(cfg[1]);
      `OFS_CH2_CONTROL: next_rdata = pack_control(cfg[1]);
      `OFS_CH2_POWER:   next_rdata = pack_power(cfg[1]);
      `OFS_STATUS: begin
        next_rdata[`STS_CH1_LEVEL] = st[0].level;
        next_rdata[`STS_CH2_LEVEL] = st[1].level;
        next_rdata[`STS_SYNC_HELD] = sync_sync;
        next_rdata[`STS_CH1_RUN]   = st[0].running;
        next_rdata[`STS_CH2_RUN]   = st[1].running;
      end
      default:          next_rdata = `RST_DATA;
    endcase
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      RDATA_O <= `RST_DATA;
    end else if (CE_I) begin
      RDATA_O <= RD_I ? next_rdata : `RST_DATA;
    end
  end

endmodule : clkdiv_top

// ---- testbench/clkdiv_checker.sv ----
// port assertions for the channel divider block
`timescale 1ns/1ps
`include "clkdiv_consts.svh"

module clkdiv_checker #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic                      CLK_I,
  input wire logic                      SYS_RST_I,
  input wire logic                      CE_I,
  // register port
  input wire logic [`CLKDIV_ADDR_W-1:0] ADDR_I,
  input wire logic [`CLKDIV_DATA_W-1:0] WDATA_I,
  input wire logic                      WR_I,
  // divider side
  input wire logic [CHANNELS-1:0]       DIV_O,
  input wire logic [CHANNELS-1:0]       BYPASS_O,
  input wire logic [CHANNELS*3-1:0]     OUT_EN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_wr_pwr2;
    CE_I && WR_I && ADDR_I == `OFS_CH2_POWER;
  endsequence
  sequence s_byp_on;
    CE_I && WR_I && ADDR_I == `OFS_CH2_CONTROL && WDATA_I[`FLD_BYPASS];
  endsequence
  sequence s_force_hi;
    CE_I && WR_I && ADDR_I == `OFS_CH1_CONTROL && WDATA_I[7:5] == 3'b011;
  endsequence

  a_pairs_grouped1: assert property (
    OUT_EN_O[2:0] == 3'h0 || OUT_EN_O[2:0] == 3'h7)
    else $error("channel one pair enables split");
  a_pairs_grouped2: assert property (
    OUT_EN_O[5:3] == 3'h0 || OUT_EN_O[5:3] == 3'h7)
    else $error("channel two pair enables split");
  a_pd_off_pairs: assert property (
    s_wr_pwr2 ##0 WDATA_I[`FLD_POWER_DOWN] ##1 CE_I [*2]
      |-> OUT_EN_O[5:3] == 3'h0)
    else $error("power-down left pairs enabled");
  a_pd_on_pairs: assert property (
    s_wr_pwr2 ##0 !WDATA_I[`FLD_POWER_DOWN] ##1 CE_I [*2]
      |-> OUT_EN_O[5:3] == 3'h7)
    else $error("power-up left pairs disabled");
  a_bypass_flag: assert property (
    s_byp_on ##1 CE_I [*2] |-> BYPASS_O[1])
    else $error("bypass write not shown");
  a_bypass_quiet1: assert property (
    BYPASS_O[0] && $past(BYPASS_O[0]) |-> !DIV_O[0])
    else $error("divider one runs in bypass");
  a_bypass_quiet2: assert property (
    BYPASS_O[1] && $past(BYPASS_O[1]) |-> !DIV_O[1])
    else $error("divider two runs in bypass");
  a_force_high: assert property (
    s_force_hi ##1 CE_I [*4] |-> DIV_O[0])
    else $error("forced high output not high");
endmodule : clkdiv_checker

bind clkdiv_top clkdiv_checker #(.CHANNELS(CHANNELS)) u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .DIV_O(DIV_O), .BYPASS_O(BYPASS_O),
  .OUT_EN_O(OUT_EN_O));

// ---- testbench/clkdiv_top_bench.sv ----
// self-checking bench for the two-channel divider block
`timescale 1ns/1ps
`include "clkdiv_consts.svh"

module clkdiv_top_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [11:0] addr = 12'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        sync_in = 1'b0;
  logic [7:0]  rdata;
  logic [1:0]  div;
  logic [1:0]  bypass;
  logic [5:0]  out_en;
  int          n_mismatch = 0;
  int          checks = 0;
  int          hi;
  int          lo;
  int          base;
  int          i;
  logic [11:0] ofs_tab [6] = '{`OFS_CH1_COUNTS, `OFS_CH1_CONTROL,
    `OFS_CH1_POWER, `OFS_CH2_COUNTS, `OFS_CH2_CONTROL, `OFS_CH2_POWER};
  logic [7:0]  rst_tab [6] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
  logic [7:0]  pat_tab [6] = '{8'h5A, 8'h1F, 8'h05, 8'hC3, 8'h2E, 8'h05};
  logic [7:0]  cnt_tab [4] = '{8'h00, 8'h25, 8'hF3, 8'h12};
  logic [7:0]  pwr_tab [4] = '{8'h01, 8'h01, 8'h01, 8'h00};

  always #2 clk = ~clk;

  clkdiv_top #(.CHANNELS(2)) uut (
    .CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SYNC_I(sync_in), .DIV_O(div), .BYPASS_O(bypass), .OUT_EN_O(out_en));

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : reg_rd

  // bounded wait: a hang counts as a mismatch and ends the run
  task automatic wait_lvl(input int ch, input logic lvl);
    for (int k = 0; k < 200 && div[ch] !== lvl; k++) step(1);
    if (div[ch] !== lvl) begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_lvl

  task automatic run_len(input int ch, output int n);
    logic lvl;
    lvl = div[ch];
    n = 0;
    while (div[ch] === lvl && n < 100) begin
      n++;
      step(1);
    end
  endtask : run_len

  // both channels obey sync with the same setting, so they must realign
  task automatic sync_run(input logic [7:0] ctl, output int n);
    int bad;
    bad = 0;
    reg_wr(`OFS_CH1_CONTROL, ctl);
    reg_wr(`OFS_CH2_CONTROL, ctl);
    @(posedge clk) sync_in <= 1'b1;
    step(8);
    check(div, {2{ctl[5]}});
    reg_rd(`OFS_STATUS, {5'h00, 1'b1, {2{ctl[5]}}});
    @(posedge clk) sync_in <= 1'b0;
    #1;
    wait_lvl(0, ctl[4]);
    run_len(0, n);
    for (int k = 0; k < 16; k++) begin
      if (div[0] !== div[1]) bad++;
      step(1);
    end
    check(bad[7:0], 8'h00);
  endtask : sync_run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    step(2);
    check({2'b00, out_en}, 8'h3F);
    for (i = 0; i < 6; i++) reg_rd(ofs_tab[i], rst_tab[i]);
    for (i = 0; i < 6; i++) reg_wr(ofs_tab[i], pat_tab[i]);
    for (i = 0; i < 6; i++) reg_rd(ofs_tab[i], pat_tab[i]);
    for (i = 0; i < 6; i++) reg_wr(ofs_tab[i], rst_tab[i]);
    reg_wr(12'h0199, 8'hFF);
    reg_rd(12'h0199, 8'h00);
    // segment lengths, with and without duty correction
    for (i = 0; i < 4; i++) begin
      reg_wr(`OFS_CH2_COUNTS, cnt_tab[i]);
      reg_wr(`OFS_CH2_POWER, pwr_tab[i]);
      base = cnt_tab[i][7:4] + cnt_tab[i][3:0] + 2;
      step(40);
      wait_lvl(1, 1'b0);
      wait_lvl(1, 1'b1);
      run_len(1, hi);
      run_len(1, lo);
      if (pwr_tab[i][0]) begin
        check(hi[7:0], cnt_tab[i][3:0] + 8'h01);
        check(lo[7:0], cnt_tab[i][7:4] + 8'h01);
      end else begin
        check(hi[7:0], base / 2);
        check(lo[7:0], base - base / 2);
      end
    end
    reg_wr(`OFS_CH2_COUNTS, 8'h33);
    reg_wr(`OFS_CH2_POWER, 8'h00);
    // a write while the enable is low must not land
    @(posedge clk) ce <= 1'b0;
    reg_wr(`OFS_CH2_COUNTS, 8'hFF);
    @(posedge clk) ce <= 1'b1;
    reg_rd(`OFS_CH2_COUNTS, 8'h33);
    // bypass raises both flags and stops divider two
    reg_wr(`OFS_CH1_CONTROL, 8'h80);
    reg_wr(`OFS_CH2_CONTROL, 8'h80);
    step(3);
    check({6'h00, bypass}, 8'h03);
    hi = 0;
    for (i = 0; i < 10; i++) begin
      hi += div[1];
      step(1);
    end
    check(hi[7:0], 8'h00);
    reg_wr(`OFS_CH1_CONTROL, 8'h00);
    reg_wr(`OFS_CH2_CONTROL, 8'h00);
    reg_wr(`OFS_CH2_POWER, 8'h04);
    step(3);
    check({2'b00, out_en}, 8'h07);
    reg_wr(`OFS_CH2_POWER, 8'h00);
    step(3);
    check({2'b00, out_en}, 8'h3F);
    // forced high and ignoring channels are deaf to sync
    reg_wr(`OFS_CH1_CONTROL, 8'h60);
    reg_wr(`OFS_CH2_CONTROL, 8'h40);
    step(4);
    @(posedge clk) sync_in <= 1'b1;
    step(3);
    hi = 0;
    lo = 0;
    for (i = 0; i < 16; i++) begin
      hi += div[1];
      lo += !div[0];
      step(1);
    end
    check(hi[7:0], 8'h08);
    check(lo[7:0], 8'h00);
    @(posedge clk) sync_in <= 1'b0;
    step(4);
    // restart level and phase offset after a sync event
    sync_run(8'h20, lo);
    sync_run(8'h10, base);
    sync_run(8'h15, hi);
    check(hi[7:0] - base[7:0], 8'h05);
    close_out();
  end
endmodule : clkdiv_top_bench
